// [logic/arx_rx_port.sv]
// receive side of the audio serial port: framing, sync checks, status, converter control
`timescale 1ns/1ns
module arx_rx_port
    import arx_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              SCLK,
    input  wire logic              LRCK,
    input  wire logic              SDIN,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [31:0]       WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [31:0]       RDATA,
    output logic                   INT_OUT,
    output logic      [WORD_W-1:0] PLAY_DATA,
    output logic                   PLAY_CHAN,
    output logic                   PLAY_VALID,
    output logic                   PLAY_BYPASS,
    output logic                   BAND_LIMIT,
    output logic      [1:0]        CONV_CLK_SEL,
    output logic      [4:0]        CONV_CLK_MHZ,
    output logic                   SAMPLE_CLK_EN,
    output logic                   POWERDOWN
);
    function automatic logic [4:0] clk_mhz(input logic [1:0] code);
        unique case (code)
            CSEL_6M:  clk_mhz = 5'h06;
            CSEL_12M: clk_mhz = 5'h0C;
            default:  clk_mhz = 5'h18;  // 11 and the table's 10 both mean the fastest clock
        endcase
    endfunction

    arx_ctrl_t        ctrl_q;
    arx_frame_t       frm_q;
    logic [ST_W-1:0]  status_q, mask_q;
    logic [3:0]       rate_in_q, rate_out_q;
    logic [2:0]       sclk_s, lrck_s, sdin_s;
    logic             sclk_rise, lvl, prev_lvl_q, sync_edge, half_eff;
    logic             in_frame_q, frame_go, early_armed_q, frame_on;
    logic [CNT_W-1:0] pos_q, pos_cur, phase_cnt_q, phase_len, expected;
    logic [CNT_W:0]   nosync_q;
    logic             ev_early, ev_late, ev_miss, ev_ovld;
    logic [WORD_W-1:0] shift_q [NCH];
    logic [WORD_W-1:0] word_q  [NCH];
    logic [NCH-1:0]   pend_q, done;
    logic [ST_W-1:0]  st_set, st_clr;

    // pins cross in through two flops; only the second stage and later is read
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sclk_s <= 3'h0;
            lrck_s <= 3'h0;
            sdin_s <= 3'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], SCLK};
            lrck_s <= {lrck_s[1:0], LRCK};
            sdin_s <= {sdin_s[1:0], SDIN};
        end
    end

    assign sclk_rise = sclk_s[1] & ~sclk_s[2];
    assign lvl       = lrck_s[1];
    assign sync_edge = sclk_rise & (lvl != prev_lvl_q);
    assign half_eff  = ctrl_q.half_duty_mode_en & ~ctrl_q.double_rate_select;

    // half-duty: the chosen edge starts a frame only if the line sat at the other level on the previous bit clock
    always_comb begin
        if (ctrl_q.half_duty_mode_en)
            frame_go = sync_edge & (lvl == ctrl_q.frame_start_phase);
        else
            frame_go = sync_edge & lvl;
    end

    // bit location: per phase in half-duty without double rate, per frame otherwise
    always_comb begin
        if (half_eff ? sync_edge : frame_go)
            pos_cur = '0;
        else
            pos_cur = pos_q + 13'h0001;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            prev_lvl_q <= 1'b0;
            pos_q      <= '0;
            in_frame_q <= 1'b0;
        end else if (sclk_rise) begin
            prev_lvl_q <= lvl;
            pos_q      <= pos_cur;
            if (!ctrl_q.port_en)
                in_frame_q <= 1'b0;
            else if (frame_go)
                in_frame_q <= 1'b1;
        end
    end

    // the edge that opens a frame already carries its first bit, so capture cannot wait for the flop
    assign frame_on = in_frame_q | (frame_go & ctrl_q.port_en);

    // phase length checks
    assign phase_len = phase_cnt_q;
    assign expected  = prev_lvl_q ? frm_q.sync_high_width
                                  : frm_q.sync_period_setting - frm_q.sync_high_width;
    assign ev_early  = sync_edge & in_frame_q & (phase_len < expected) & early_armed_q;
    assign ev_late   = sync_edge & in_frame_q & (phase_len > expected);
    assign ev_miss   = sclk_rise & ctrl_q.port_en & ~sync_edge
                     & (nosync_q > {frm_q.sync_period_setting, 1'b0});

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            phase_cnt_q <= '0;
        end else if (sclk_rise) begin
            if (sync_edge)
                phase_cnt_q <= 13'h0001;
            else if (phase_cnt_q != '1)
                phase_cnt_q <= phase_cnt_q + 13'h0001;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            nosync_q <= '0;
        end else if (sclk_rise) begin
            if (sync_edge)
                nosync_q <= '0;
            else if (nosync_q != '1)
                nosync_q <= nosync_q + 14'h0001;
        end
    end

    // one early report, then silence until a transition of the right length
    always_ff @(posedge CLK) begin
        if (!RST_N)
            early_armed_q <= 1'b1;
        else if (ev_early)
            early_armed_q <= 1'b0;
        else if (sync_edge && phase_len == expected)
            early_armed_q <= 1'b1;
    end

    // capture channels
    for (genvar c = 0; c < NCH; c++) begin : g_chan
        logic [11:0] loc;
        logic        phase_ok, in_slot, last_bit;
        assign loc      = (c == 0) ? frm_q.loc1 : frm_q.loc2;
        assign phase_ok = !half_eff || (lvl == ctrl_q.chan_phase_sel[c]);
        assign in_slot  = ({1'b0, loc} <= pos_cur)
                        && (pos_cur < {1'b0, loc} + {8'h00, frm_q.res});
        assign last_bit = pos_cur == {1'b0, loc} + {8'h00, frm_q.res} - 13'h0001;
        assign done[c]  = sclk_rise & frame_on & phase_ok & last_bit;
        always_ff @(posedge CLK) begin
            if (!RST_N) begin
                shift_q[c] <= '0;
                word_q[c]  <= '0;
            end else if (sclk_rise && frame_on && phase_ok && in_slot) begin
                shift_q[c] <= {shift_q[c][WORD_W-2:0], sdin_s[1]};
                if (last_bit)
                    word_q[c] <= {shift_q[c][WORD_W-2:0], sdin_s[1]} << (5'd24 - frm_q.res);
            end
        end
    end

    // one word served per cycle, channel 1 first; a second request on a busy slot overloads
    assign ev_ovld = |(done & pend_q);
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pend_q     <= '0;
            PLAY_VALID <= 1'b0;
            PLAY_CHAN  <= 1'b0;
            PLAY_DATA  <= '0;
        end else begin
            PLAY_VALID <= 1'b0;
            if (pend_q[0]) begin
                PLAY_VALID <= 1'b1;
                PLAY_CHAN  <= 1'b0;
                PLAY_DATA  <= word_q[0];
            end else if (pend_q[1]) begin
                PLAY_VALID <= 1'b1;
                PLAY_CHAN  <= 1'b1;
                PLAY_DATA  <= word_q[1];
            end
            pend_q[0] <= done[0] | (pend_q[0] & 1'b0);
            pend_q[1] <= done[1] | (pend_q[1] & pend_q[0]);
        end
    end

    // sticky status, set beats clear
    always_comb begin
        st_set           = '0;
        st_set[SB_OVLD]  = ev_ovld;
        st_set[SB_EARLY] = ev_early;
        st_set[SB_LATE]  = ev_late;
        st_set[SB_ERR]   = ev_early | ev_late;
        st_set[SB_MISS]  = ev_miss;
        st_clr           = (WR && ADDR == OFS_STATUS) ? WDATA[ST_W-1:0] : '0;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N)
            status_q <= '0;
        else
            status_q <= (status_q & ~st_clr) | st_set;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N)
            INT_OUT <= 1'b0;
        else
            INT_OUT <= |(((status_q & ~st_clr) | st_set) & ~mask_q);
    end

    // register writes
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_q     <= RST_CTRL;
            frm_q      <= {RST_PERIOD, RST_HIGH, 24'h000000, RST_RES};
            mask_q     <= RST_MASK;
            rate_in_q  <= '0;
            rate_out_q <= '0;
        end else if (WR) begin
            unique case (ADDR)
                OFS_CTRL:   ctrl_q <= WDATA[10:0];
                OFS_PERIOD: frm_q.sync_period_setting <= WDATA[CNT_W-1:0];
                OFS_HIGH:   frm_q.sync_high_width <= WDATA[CNT_W-1:0];
                OFS_LOC: begin
                    frm_q.loc1 <= WDATA[11:0];
                    frm_q.loc2 <= WDATA[27:16];
                end
                OFS_RES:    frm_q.res <= WDATA[4:0];
                OFS_MASK:   mask_q <= WDATA[ST_W-1:0];
                OFS_RATE: begin
                    rate_in_q  <= WDATA[3:0];
                    rate_out_q <= WDATA[7:4];
                end
                default: ;
            endcase
        end
    end

    // reads answer one cycle later; unmapped reads give zero
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RDATA <= '0;
        end else if (RD) begin
            unique case (ADDR)
                OFS_CTRL:   RDATA <= {21'h0, ctrl_q};
                OFS_PERIOD: RDATA <= {19'h0, frm_q.sync_period_setting};
                OFS_HIGH:   RDATA <= {19'h0, frm_q.sync_high_width};
                OFS_LOC:    RDATA <= {4'h0, frm_q.loc2, 4'h0, frm_q.loc1};
                OFS_RES:    RDATA <= {27'h0, frm_q.res};
                OFS_STATUS: RDATA <= {27'h0, status_q};
                OFS_MASK:   RDATA <= {27'h0, mask_q};
                OFS_DATA1:  RDATA <= {8'h0, word_q[0]};
                OFS_DATA2:  RDATA <= {8'h0, word_q[1]};
                OFS_RATE:   RDATA <= {24'h0, rate_out_q, rate_in_q};
                default:    RDATA <= '0;
            endcase
        end else begin
            RDATA <= '0;
        end
    end

    // converter control; settings are only safe to change around a power cycle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PLAY_BYPASS   <= 1'b0;
            BAND_LIMIT    <= 1'b0;
            CONV_CLK_SEL  <= CSEL_6M;
            CONV_CLK_MHZ  <= 5'h06;
            SAMPLE_CLK_EN <= 1'b0;
            POWERDOWN     <= 1'b1;
        end else begin
            PLAY_BYPASS   <= ctrl_q.rate_converter_bypass;
            BAND_LIMIT    <= ~ctrl_q.rate_converter_bypass & (rate_out_q < rate_in_q);
            CONV_CLK_SEL  <= ctrl_q.converter_clock_select;
            CONV_CLK_MHZ  <= clk_mhz(ctrl_q.converter_clock_select);
            SAMPLE_CLK_EN <= ctrl_q.sample_rate_clock_en;
            POWERDOWN     <= ctrl_q.global_powerdown;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_err_or_flags: assert property (status_q[SB_ERR] || !(status_q[SB_EARLY] || status_q[SB_LATE]))
        else $error("error flag missing while early or late set");
    a_sticky_hold: assert property (status_q[SB_MISS] && !(WR && ADDR == OFS_STATUS) |=> status_q[SB_MISS])
        else $error("missing flag dropped without a clear");
    a_w1c_clear: assert property (WR && ADDR == OFS_STATUS && WDATA[SB_LATE] && !ev_late
                                  |=> !status_q[SB_LATE])
        else $error("late flag not cleared by write one");
    a_int_masked: assert property ((((status_q | st_set) & ~mask_q) == '0) |=> !INT_OUT)
        else $error("interrupt raised by masked flags");
    a_int_raise: assert property (ev_late && !mask_q[SB_LATE] |=> INT_OUT)
        else $error("unmasked late flag raised no interrupt");
    a_early_once: assert property (ev_early |=> !early_armed_q)
        else $error("early report not disarmed");
    a_late_set: assert property (ev_late |=> status_q[SB_LATE] && status_q[SB_ERR])
        else $error("late event not recorded");
    a_start_edge: assert property (ctrl_q.half_duty_mode_en && !in_frame_q && ctrl_q.port_en && sclk_rise
                                   && sync_edge && lvl == ctrl_q.frame_start_phase |=> in_frame_q)
        else $error("frame did not start on selected edge");
    a_bypass_out: assert property ($rose(ctrl_q.rate_converter_bypass) |=> PLAY_BYPASS && !BAND_LIMIT)
        else $error("bypass not forwarded");
    a_clk_code: assert property (ctrl_q.converter_clock_select == CSEL_12M |=> CONV_CLK_MHZ == 5'h0C)
        else $error("converter clock code decoded wrongly");
    a_miss_set: assert property (ev_miss |=> status_q[SB_MISS])
        else $error("missing sync not recorded");
    a_early_set: assert property (ev_early |=> status_q[SB_EARLY] && status_q[SB_ERR])
        else $error("early event not recorded");
    a_pos_restart: assert property (half_eff && sync_edge |=> pos_q == '0)
        else $error("bit location not restarted at phase start");
    a_set_wins: assert property (ev_late && WR && ADDR == OFS_STATUS |=> status_q[SB_LATE])
        else $error("late flag lost to a same-cycle clear");
endmodule // arx_rx_port

// [inc/arx_pkg.sv]
// package for the audio receive port: register map, field layout, reset values, carriers
package arx_pkg;
    localparam int         ADDR_W        = 8;
    localparam int         CNT_W         = 13;
    localparam int         WORD_W        = 24;
    localparam int         NCH           = 2;
    // byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_PERIOD    = 8'h04;
    localparam logic [7:0] OFS_HIGH      = 8'h08;
    localparam logic [7:0] OFS_LOC       = 8'h0C;
    localparam logic [7:0] OFS_RES       = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;
    localparam logic [7:0] OFS_MASK      = 8'h18;
    localparam logic [7:0] OFS_DATA1     = 8'h1C;
    localparam logic [7:0] OFS_DATA2     = 8'h20;
    localparam logic [7:0] OFS_RATE      = 8'h24;
    // control field positions
    localparam int         CB_HALF       = 0;
    localparam int         CB_STP        = 1;
    localparam int         CB_AP1        = 2;
    localparam int         CB_AP2        = 3;
    localparam int         CB_DBL        = 4;
    localparam int         CB_BYP        = 5;
    localparam int         CB_CSEL       = 6;
    localparam int         CB_FSEN       = 8;
    localparam int         CB_PDN        = 9;
    localparam int         CB_PEN        = 10;
    // status bit positions
    localparam int         SB_OVLD       = 0;
    localparam int         SB_ERR        = 1;
    localparam int         SB_EARLY      = 2;
    localparam int         SB_LATE       = 3;
    localparam int         SB_MISS       = 4;
    localparam int         ST_W          = 5;
    // reset values
    localparam logic [10:0] RST_CTRL     = 11'h200;
    localparam logic [12:0] RST_PERIOD   = 13'h0040;
    localparam logic [12:0] RST_HIGH     = 13'h0020;
    localparam logic [4:0]  RST_RES      = 5'h18;
    localparam logic [4:0]  RST_MASK     = 5'h1F;
    // converter clock codes
    localparam logic [1:0] CSEL_6M       = 2'h0;
    localparam logic [1:0] CSEL_12M      = 2'h1;
    localparam logic [1:0] CSEL_24M      = 2'h3;
    localparam logic [1:0] CSEL_TBL      = 2'h2;

    typedef struct packed {
        logic              port_en;
        logic              global_powerdown;
        logic              sample_rate_clock_en;
        logic [1:0]        converter_clock_select;
        logic              rate_converter_bypass;
        logic              double_rate_select;
        logic [NCH-1:0]    chan_phase_sel;
        logic              frame_start_phase;
        logic              half_duty_mode_en;
    } arx_ctrl_t;

    typedef struct packed {
        logic [CNT_W-1:0]  sync_period_setting;
        logic [CNT_W-1:0]  sync_high_width;
        logic [11:0]       loc1;
        logic [11:0]       loc2;
        logic [4:0]        res;
    } arx_frame_t;
endpackage

// [dv/arx_host_model.sv]
// behavioural host serial port: bit clock, frame sync and serial data
`timescale 1ns/1ns
module arx_host_model (
    input  wire logic        start,
    input  wire logic        first_hi,
    input  wire logic [12:0] lo_len,
    input  wire logic [12:0] hi_len,
    input  wire logic [15:0] w1,
    input  wire logic [15:0] w2,
    input  wire logic [3:0]  nfr,
    output logic             sclk,
    output logic             lrck,
    output logic             sdin,
    output logic             done
);
    logic        lvl;
    logic [12:0] len;
    logic [15:0] word;
    initial begin
        sclk = 1'b0;
        lrck = 1'b1;
        sdin = 1'b0;
        done = 1'b1;
        forever begin
            @(posedge start);
            done = 1'b0;
            // park sync opposite the start phase while the bit clock is stopped
            lrck = ~first_hi;
            // one lead-in bit lets the port see the parked level before the start edge
            #35 sclk = 1'b1;
            #32 sclk = 1'b0;
            for (int f = 0; f < nfr; f++) begin
                for (int ph = 0; ph < 2; ph++) begin
                    lvl  = first_hi ^ ph[0];
                    len  = lvl ? hi_len : lo_len;
                    word = ph[0] ? w2 : w1;
                    for (int b = 0; b < len; b++) begin
                        lrck = lvl;
                        sdin = (b < 16) ? word[15 - b] : ~sdin;
                        #32 sclk = 1'b1;
                        #32 sclk = 1'b0;
                    end
                end
            end
            // a released data line must not keep its last value
            sdin = ~sdin;
            done = 1'b1;
        end
    end
endmodule // arx_host_model

// [dv/arx_rx_port_bench.sv]
// self-checking bench for the audio receive port against a host link model
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; $display("Error at %0t: got %h want %h", $time, (a), (b)); end end
module arx_rx_port_bench
    import arx_pkg::*;
;
    localparam logic [15:0] W1 = 16'hA5C3;
    localparam logic [15:0] W2 = 16'h3C5A;
    logic              clk;
    logic              rst_n;
    logic [7:0]        addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
    logic [31:0]       rdata;
    logic              int_out;
    logic [23:0]       play_data;
    logic              play_chan;
    logic              play_valid;
    logic              play_bypass;
    logic              band_limit;
    logic [4:0]        conv_clk_mhz;
    logic [1:0]        conv_clk_sel;
    logic              sample_clk_en;
    logic              powerdown;
    logic              sclk;
    logic              lrck;
    logic              sdin;
    logic              m_start;
    logic              m_first_hi;
    logic [12:0]       m_lo;
    logic [12:0]       m_hi;
    logic [3:0]        m_nfr;
    logic              m_done;
    int                num_errors;
    int                tests_run;
    int                cycles;
    logic [24:0]       got [$];

    arx_rx_port i_arx_rx_port (.CLK(clk), .RST_N(rst_n), .SCLK(sclk), .LRCK(lrck), .SDIN(sdin), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .INT_OUT(int_out), .PLAY_DATA(play_data),
        .PLAY_CHAN(play_chan), .PLAY_VALID(play_valid), .PLAY_BYPASS(play_bypass), .BAND_LIMIT(band_limit),
        .CONV_CLK_SEL(conv_clk_sel), .CONV_CLK_MHZ(conv_clk_mhz), .SAMPLE_CLK_EN(sample_clk_en),
        .POWERDOWN(powerdown));
    arx_host_model i_arx_host_model (.start(m_start), .first_hi(m_first_hi), .lo_len(m_lo), .hi_len(m_hi),
        .w1(W1), .w2(W2), .nfr(m_nfr), .sclk(sclk), .lrck(lrck), .sdin(sdin), .done(m_done));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic finish_test();
        $display("mismatches %0d, comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // the ceiling is several times the longest expected run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (play_valid === 1'b1) got.push_back({play_chan, play_data});
        if (cycles == 40000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata, exp)
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        got.delete();
    endtask

    task automatic setup_link(input logic [31:0] c);
        wr_reg(OFS_PERIOD, 32'd32);
        wr_reg(OFS_HIGH, 32'd16);
        wr_reg(OFS_RES, 32'd16);
        wr_reg(OFS_LOC, 32'h0);
        wr_reg(OFS_CTRL, c);
        wr_reg(OFS_CTRL, c | 32'h400);
    endtask

    task automatic run(input logic fh, input logic [12:0] lo, input logic [12:0] hi, input logic [3:0] n);
        m_first_hi <= fh;
        m_lo       <= lo;
        m_hi       <= hi;
        m_nfr      <= n;
        m_start    <= 1'b1;
        @(posedge clk);
        m_start    <= 1'b0;
        while (m_done !== 1'b1) @(posedge clk);
        repeat (40) @(posedge clk);
        #1;
    endtask

    task automatic t_reset_vals();
        logic [7:0]  a [8];
        logic [31:0] e [8];
        a = '{OFS_CTRL, OFS_PERIOD, OFS_HIGH, OFS_LOC, OFS_RES, OFS_STATUS, OFS_MASK, 8'h28};
        e = '{32'h200, 32'h40, 32'h20, 32'h0, 32'h18, 32'h0, 32'h1F, 32'h0};
        wr_reg(8'h28, 32'hFFFFFFFF);
        for (int i = 0; i < 8; i++) rd_chk(a[i], e[i]);
        `CHK(powerdown, 1'b1)
        `CHK(int_out, 1'b0)
    endtask

    task automatic t_conv();
        logic [4:0] mhz [4];
        mhz = '{5'h06, 5'h0C, 5'h18, 5'h18};
        for (int i = 0; i < 4; i++) begin
            wr_reg(OFS_CTRL, (32'(i) << 6) | (32'(i[0]) << 5) | 32'h200);
            repeat (3) @(posedge clk);
            #1;
            `CHK(conv_clk_mhz, mhz[i])
            `CHK(conv_clk_sel, 2'(i))
            `CHK(play_bypass, i[0])
        end
        wr_reg(OFS_RATE, 32'h13);
        repeat (3) @(posedge clk);
        #1;
        `CHK(band_limit, 1'b0)
        wr_reg(OFS_CTRL, 32'h200);
        repeat (3) @(posedge clk);
        #1;
        `CHK(band_limit, 1'b1)
        wr_reg(OFS_RATE, 32'h31);
        repeat (3) @(posedge clk);
        #1;
        `CHK(band_limit, 1'b0)
    endtask

    // channels with differing phase selects; the first phase carries W1; at double rate both take it
    task automatic t_rx(input logic stp, input logic ap1, input logic ap2, input logic dbl);
        logic [24:0] first;
        logic [24:0] second;
        logic [31:0] c;
        first  = {ap1 != stp && !dbl, W1, 8'h00};
        second = dbl ? {1'b1, W1, 8'h00} : {ap1 == stp, W2, 8'h00};
        c      = {27'h0, dbl, ap2, ap1, stp, 1'b1} | 32'h100;
        do_reset();
        setup_link(c);
        run(stp, 13'd16, 13'd16, 4'd2);
        `CHK(got.size(), 4)
        foreach (got[i]) `CHK(got[i], i[0] ? second : first)
        `CHK(sample_clk_en, 1'b1)
        rd_chk(OFS_DATA1, {8'h00, (first[24] ? second[23:0] : first[23:0])});
        rd_chk(OFS_DATA2, {8'h00, (first[24] ? first[23:0] : second[23:0])});
        rd_chk(OFS_STATUS, 32'h0);
        wr_reg(OFS_CTRL, c | 32'h600);
        wr_reg(OFS_CTRL, 32'h200);
        `CHK(powerdown, 1'b1)
    endtask

    task automatic t_err(input logic [12:0] lo, input logic [12:0] hi, input logic [3:0] n, input logic [31:0] exp);
        do_reset();
        setup_link(32'h101);
        run(1'b0, lo, hi, n);
        `CHK(int_out, 1'b0)
        rd_chk(OFS_STATUS, exp);
        repeat (50) @(posedge clk);
        rd_chk(OFS_STATUS, exp);
        wr_reg(OFS_MASK, 32'h0);
        repeat (3) @(posedge clk);
        #1;
        `CHK(int_out, 1'b1)
        wr_reg(OFS_STATUS, exp);
        rd_chk(OFS_STATUS, 32'h0);
        `CHK(int_out, 1'b0)
    endtask

    initial begin
        rst_n      = 1'b0;
        addr       = 8'h00;
        wdata      = 32'h0;
        wr         = 1'b0;
        rd         = 1'b0;
        m_start    = 1'b0;
        m_first_hi = 1'b0;
        m_lo       = 13'd16;
        m_hi       = 13'd16;
        m_nfr      = 4'd1;
        num_errors = 0;
        tests_run  = 0;
        cycles     = 0;
        do_reset();
        t_reset_vals();
        t_conv();
        t_rx(1'b0, 1'b0, 1'b1, 1'b0);
        t_rx(1'b1, 1'b0, 1'b1, 1'b0);
        t_rx(1'b0, 1'b1, 1'b0, 1'b0);
        t_rx(1'b1, 1'b1, 1'b0, 1'b0);
        t_rx(1'b0, 1'b1, 1'b0, 1'b1);
        t_err(13'd16, 13'd17, 4'd2, 32'h0A);
        t_err(13'd16, 13'd15, 4'd2, 32'h06);
        t_err(13'd70, 13'd16, 4'd1, 32'h1A);
        finish_test();
    end
endmodule // arx_rx_port_bench
